// ===== rns_pkg.sv
`default_nettype none
package rns_pkg;
	localparam int RNS_SLOTS = 10;
	localparam int RNS_DIGITS = 22;
	localparam int RNS_CLK_HZ = 200_000_000;
	localparam int RNS_STEP_MS = 60;
	localparam int RNS_STEP_CYC = (RNS_CLK_HZ / 1000) * RNS_STEP_MS;
	localparam int RNS_DEB_MS = 5;
	localparam int RNS_DEB_CYC = (RNS_CLK_HZ / 1000) * RNS_DEB_MS;
	localparam int RNS_FIFO_DEPTH = 8;
	// Bus codes as seen on the lines, line 1 in bit 3.
	localparam logic [3:0] RNS_CODE_1 = 4'hF;
	localparam logic [3:0] RNS_CODE_2 = 4'hE;
	localparam logic [3:0] RNS_CODE_3 = 4'hD;
	localparam logic [3:0] RNS_CODE_4 = 4'hB;
	localparam logic [3:0] RNS_CODE_5 = 4'hA;
	localparam logic [3:0] RNS_CODE_6 = 4'h9;
	localparam logic [3:0] RNS_CODE_7 = 4'h7;
	localparam logic [3:0] RNS_CODE_8 = 4'h6;
	localparam logic [3:0] RNS_CODE_9 = 4'h5;
	localparam logic [3:0] RNS_CODE_0 = 4'hC;
	localparam logic [3:0] RNS_CODE_PAUSE = 4'h3;
	typedef enum logic [2:0]
	{
		RNS_IDLE = 3'b000,
		RNS_STORE_ADDR = 3'b001,
		RNS_STORE_DIG = 3'b010,
		RNS_RET_ADDR = 3'b011,
		RNS_RET_WAIT = 3'b100,
		RNS_RET_ON = 3'b101,
		RNS_RET_OFF = 3'b110,
		RNS_DONE = 3'b111
	} rns_state_t;
endpackage
`default_nettype wire

// ===== rns_fifo.sv
`default_nettype none
module rns_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input wire logic i_mclk,
	input wire logic i_reset,
	// Fill side.
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// Drain side.
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	// Full and empty come straight from the fill count.
	assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign o_valid = (cnt_reg != '0);
	assign o_data = mem_reg[rp_reg];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	// Storage is written only on an accepted word.
	always_ff @(posedge i_mclk)
	begin
		if (push)
			mem_reg[wp_reg] <= i_data;
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
			if (pop)
				rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule // rns_fifo
`default_nettype wire

// ===== rns_store.sv
`default_nettype none
module rns_store
	import rns_pkg::*;
#(
	parameter int STEP_CYC = rns_pkg::RNS_STEP_CYC,
	parameter int DEB_CYC = rns_pkg::RNS_DEB_CYC
) (
	// Clock, reset and power-on reset.
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_por_n,
	// Control inputs.
	input wire logic i_retrieve,
	input wire logic i_seq_enable,
	input wire logic i_store,
	input wire logic i_unit_sel,
	// Key strobe in and out, out active low with an enable.
	input wire logic i_key_strobe_n,
	output logic o_key_strobe_n,
	output logic o_key_strobe_oe,
	// Shared code lines, line 1 in bit 3.
	input wire logic [3:0] i_code_line,
	output logic [3:0] o_code_line,
	output logic [3:0] o_code_line_oe,
	// Keyboard disables, active low.
	output logic o_digit_kb_dis_n,
	output logic o_addr_kb_dis_n
);
	import rns_pkg::*;

	logic [3:0] mem_reg [RNS_SLOTS][RNS_DIGITS];
	logic [4:0] len_reg [RNS_SLOTS];
	rns_state_t state_reg;
	logic [3:0] addr_reg;
	logic [4:0] idx_reg;
	logic [31:0] tmr_reg;
	logic [3:0] deb_reg;
	logic [31:0] dcnt_reg [4];
	logic key_prev_reg;
	logic call_done_reg;
	logic run;
	logic key_fall;
	logic f_ready;
	logic f_valid;
	logic f_pop;
	logic [3:0] f_data;
	logic retrieving;
	logic [3:0] raw;

	// Maps a bus code to a slot or digit value 0..9; 15 marks no digit.
	function automatic logic [3:0] rns_decode(input logic [3:0] c);
		case (c)
			RNS_CODE_0: rns_decode = 4'h0;
			RNS_CODE_1: rns_decode = 4'h1;
			RNS_CODE_2: rns_decode = 4'h2;
			RNS_CODE_3: rns_decode = 4'h3;
			RNS_CODE_4: rns_decode = 4'h4;
			RNS_CODE_5: rns_decode = 4'h5;
			RNS_CODE_6: rns_decode = 4'h6;
			RNS_CODE_7: rns_decode = 4'h7;
			RNS_CODE_8: rns_decode = 4'h8;
			RNS_CODE_9: rns_decode = 4'h9;
			default: rns_decode = 4'hF;
		endcase
	endfunction

	// Power-on reset low clears exactly like the system reset.
	assign run = !i_reset && i_por_n;
	assign raw = {i_key_strobe_n, i_store, i_seq_enable, i_retrieve};

	// Debouncers: bit 0 retrieve, 1 enable, 2 store, 3 key strobe.
	// The count restarts whenever the input agrees with the held value, so bounce never passes.
	always_ff @(posedge i_mclk)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (!run)
			begin
				deb_reg[k] <= (k == 3);
				dcnt_reg[k] <= '0;
			end
			else if (raw[k] == deb_reg[k])
				dcnt_reg[k] <= '0;
			else if (dcnt_reg[k] >= 32'(DEB_CYC - 1))
			begin
				deb_reg[k] <= raw[k];
				dcnt_reg[k] <= '0;
			end
			else
				dcnt_reg[k] <= dcnt_reg[k] + 1'b1;
		end
	end

	// One pulse per debounced closure of the key strobe.
	always_ff @(posedge i_mclk)
	begin
		if (!run)
			key_prev_reg <= 1'b1;
		else
			key_prev_reg <= deb_reg[3];
	end
	assign key_fall = key_prev_reg && !deb_reg[3];

	// Keyed codes queue here while the control logic is busy replaying a slot;
	// RNS_DONE and RNS_IDLE then pop them without using them.
	rns_fifo #(.WIDTH(4), .DEPTH(RNS_FIFO_DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_reset(!run),
		.i_valid(key_fall && i_unit_sel && deb_reg[1]),
		.o_ready(f_ready),
		.i_data(i_code_line),
		.o_valid(f_valid),
		.i_ready(f_pop),
		.o_data(f_data)
	);
	// A full queue drops the key; the control pops in every state but RNS_RET_WAIT, RNS_RET_ON and RNS_RET_OFF.
	assign f_pop = (state_reg == RNS_STORE_ADDR) ||
		(state_reg == RNS_STORE_DIG) || (state_reg == RNS_RET_ADDR) ||
		(state_reg == RNS_IDLE) || (state_reg == RNS_DONE);

	// Sequencer for store, erase and retrieve.
	always_ff @(posedge i_mclk)
	begin
		if (!run || !deb_reg[1] || !i_unit_sel && !deb_reg[2])
		begin
			state_reg <= RNS_IDLE;
			addr_reg <= '0;
			idx_reg <= '0;
			tmr_reg <= '0;
		end
		else
		begin
			case (state_reg)
				RNS_IDLE:
				begin
					if (deb_reg[2])
						state_reg <= RNS_STORE_ADDR;
					else if (deb_reg[0] && !call_done_reg)
						state_reg <= RNS_RET_ADDR;
				end
				RNS_STORE_ADDR:
				begin
					if (!deb_reg[2])
						state_reg <= RNS_IDLE;
					else if (f_valid && rns_decode(f_data) != 4'hF)
					begin
						addr_reg <= rns_decode(f_data);
						idx_reg <= '0;
						state_reg <= RNS_STORE_DIG;
					end
				end
				RNS_STORE_DIG:
				begin
					if (!deb_reg[2])
						state_reg <= RNS_IDLE;
				end
				RNS_RET_ADDR:
				begin
					if (f_valid && rns_decode(f_data) != 4'hF)
					begin
						addr_reg <= rns_decode(f_data);
						idx_reg <= '0;
						tmr_reg <= '0;
						state_reg <= RNS_RET_WAIT;
					end
				end
				RNS_RET_WAIT, RNS_RET_OFF:
				begin
					if (tmr_reg >= 32'(STEP_CYC - 1))
					begin
						tmr_reg <= '0;
						if (idx_reg >= len_reg[addr_reg])
							state_reg <= deb_reg[0] ?
								RNS_RET_WAIT : RNS_DONE;
						else
							state_reg <= RNS_RET_ON;
						if (idx_reg >= len_reg[addr_reg])
							idx_reg <= '0;
					end
					else
						tmr_reg <= tmr_reg + 1'b1;
				end
				RNS_RET_ON:
				begin
					if (tmr_reg >= 32'(STEP_CYC - 1))
					begin
						tmr_reg <= '0;
						idx_reg <= idx_reg + 1'b1;
						state_reg <= RNS_RET_OFF;
					end
					else
						tmr_reg <= tmr_reg + 1'b1;
				end
				RNS_DONE:
					state_reg <= RNS_DONE;
				default:
					state_reg <= RNS_IDLE;
			endcase
		end
	end

	// A finished transfer blocks addresses until the enable drops.
	always_ff @(posedge i_mclk)
	begin
		if (!run || !deb_reg[1])
			call_done_reg <= 1'b0;
		else if (state_reg == RNS_DONE)
			call_done_reg <= 1'b1;
	end

	// Slot lengths: erase on address, append on digit or pause.
	always_ff @(posedge i_mclk)
	begin
		if (!run)
		begin
			for (int s = 0; s < RNS_SLOTS; s++)
				len_reg[s] <= '0;
		end
		else if (state_reg == RNS_STORE_ADDR && deb_reg[2] && f_valid &&
			rns_decode(f_data) != 4'hF)
			len_reg[rns_decode(f_data)] <= '0;
		else if (state_reg == RNS_STORE_DIG && deb_reg[2] && f_valid &&
			i_unit_sel && (rns_decode(f_data) != 4'hF ||
			f_data == RNS_CODE_PAUSE) &&
			len_reg[addr_reg] < 5'(RNS_DIGITS))
			len_reg[addr_reg] <= len_reg[addr_reg] + 1'b1;
	end

	// Digit storage keeps the raw bus code for replay.
	always_ff @(posedge i_mclk)
	begin
		if (state_reg == RNS_STORE_DIG && deb_reg[2] && f_valid &&
			(rns_decode(f_data) != 4'hF || f_data == RNS_CODE_PAUSE) &&
			len_reg[addr_reg] < 5'(RNS_DIGITS))
			mem_reg[addr_reg][len_reg[addr_reg]] <= f_data;
	end

	assign retrieving = (state_reg == RNS_RET_WAIT) ||
		(state_reg == RNS_RET_ON) || (state_reg == RNS_RET_OFF);

	// Outputs are registered; the code lines rest high while not driven.
	always_ff @(posedge i_mclk)
	begin
		if (!run)
		begin
			o_code_line <= 4'hF;
			o_code_line_oe <= 4'h0;
			o_digit_kb_dis_n <= 1'b1;
			o_addr_kb_dis_n <= 1'b1;
			o_key_strobe_n <= 1'b1;
			o_key_strobe_oe <= 1'b1;
		end
		else
		begin
			o_digit_kb_dis_n <= !(i_unit_sel && retrieving);
			o_addr_kb_dis_n <= !(i_unit_sel && (retrieving ||
				state_reg == RNS_STORE_DIG));
			if (state_reg == RNS_RET_ON && i_unit_sel)
			begin
				o_code_line <= mem_reg[addr_reg][idx_reg];
				o_code_line_oe <= 4'hF;
			end
			else
			begin
				o_code_line <= 4'hF;
				o_code_line_oe <= 4'h0;
			end
			if (!i_unit_sel && !i_seq_enable)
			begin
				o_key_strobe_n <= i_key_strobe_n;
				o_key_strobe_oe <= 1'b1;
			end
			else if (!i_unit_sel)
			begin
				o_key_strobe_n <= 1'b1;
				o_key_strobe_oe <= 1'b0;
			end
			else if (state_reg == RNS_RET_ON)
			begin
				o_key_strobe_n <= 1'b0;
				o_key_strobe_oe <= 1'b1;
			end
			else if (state_reg == RNS_DONE ||
				(state_reg == RNS_IDLE && !deb_reg[1]))
			begin
				o_key_strobe_n <= i_key_strobe_n;
				o_key_strobe_oe <= 1'b1;
			end
			else
			begin
				o_key_strobe_n <= 1'b1;
				o_key_strobe_oe <= 1'b1;
			end
		end
	end

	// Apart from passing the keyboard strobe on, the strobe only falls while the stored code stands on the lines.
	strobe_code_a: assert property (@(posedge i_mclk) disable iff (!run)
		!o_key_strobe_n && i_unit_sel && state_reg != RNS_DONE &&
		deb_reg[1] |-> o_code_line_oe == 4'hF)
		else $error("strobe without driven code");
	// Store mode never lets a strobe reach the dialler.
	store_quiet_a: assert property (@(posedge i_mclk) disable iff (!run)
		$past(state_reg) == RNS_STORE_DIG && $past(i_unit_sel) &&
		state_reg == RNS_STORE_DIG |-> o_key_strobe_n)
		else $error("strobe during store");
	// Disable follows the transfer a cycle later.
	digit_dis_a: assert property (@(posedge i_mclk) disable iff (!run)
		retrieving && i_unit_sel |=> !o_digit_kb_dis_n)
		else $error("digit keyboard not disabled");
	addr_dis_a: assert property (@(posedge i_mclk) disable iff (!run)
		state_reg == RNS_STORE_DIG && i_unit_sel |=> !o_addr_kb_dis_n)
		else $error("address keyboard not disabled");
	length_cap_a: assert property (@(posedge i_mclk) disable iff (!run)
		len_reg[addr_reg] <= 5'(RNS_DIGITS))
		else $error("slot length over limit");
	enable_drop_a: assert property (@(posedge i_mclk) disable iff (!run)
		!deb_reg[1] |=> state_reg == RNS_IDLE)
		else $error("control not reset");
	pass_through_a: assert property (@(posedge i_mclk) disable iff (!run)
		!i_unit_sel && !i_seq_enable |=>
		o_key_strobe_n == $past(i_key_strobe_n))
		else $error("strobe not copied");
	driver_off_a: assert property (@(posedge i_mclk) disable iff (!run)
		!i_unit_sel && i_seq_enable |=> !o_key_strobe_oe)
		else $error("strobe driver left on");
	erase_slot_a: assert property (@(posedge i_mclk) disable iff (!run)
		$rose(state_reg == RNS_STORE_DIG) |-> len_reg[addr_reg] == '0)
		else $error("slot not erased");
endmodule // rns_store
`default_nettype wire

// ===== rns_dialler_model.sv
`default_nettype none
module rns_dialler_model
	import rns_pkg::*;
(
	// Clock.
	input wire logic i_mclk,
	// Store side of the strobe and code lines.
	input wire logic i_strobe_n,
	input wire logic i_strobe_oe,
	input wire logic [3:0] i_code,
	input wire logic [3:0] i_code_oe,
	// Keyboard strobe and the resolved shared lines.
	output logic o_key_strobe_n,
	output logic [3:0] o_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] kbd_code = 4'hF;
	logic [3:0] held = 4'hF;
	logic [3:0] got[$];
	logic was_low = 1'b0;
	initial o_key_strobe_n = 1'b1;
	// A line follows the store while it drives, else the keyboard code.
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			o_bus[i] = i_code_oe[i] ? i_code[i] : kbd_code[i];
	end
	// The dialler takes the code held while its strobe input was low.
	always @(posedge i_mclk)
	begin
		if (i_strobe_oe && !i_strobe_n)
			held <= o_bus;
		if (was_low && i_strobe_n)
			got.push_back(held);
		was_low <= i_strobe_oe && !i_strobe_n;
	end
	// One key depression, held well past the bounce filter.
	task automatic press(input logic [3:0] key);
		kbd_code = key;
		o_key_strobe_n = 1'b0;
		repeat (12) @(posedge i_mclk);
		#1;
		o_key_strobe_n = 1'b1;
		kbd_code = 4'hF;
		repeat (12) @(posedge i_mclk);
		#1;
	endtask
endmodule // rns_dialler_model
`default_nettype wire

// ===== test_repertory_number_store.sv
`default_nettype none
module test_repertory_number_store
	import rns_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 20;
	localparam int DEB = 4;
	localparam logic [3:0] DIG[10] = '{RNS_CODE_0, RNS_CODE_1, RNS_CODE_2,
		RNS_CODE_3, RNS_CODE_4, RNS_CODE_5, RNS_CODE_6, RNS_CODE_7,
		RNS_CODE_8, RNS_CODE_9};
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic por_n = 1'b0;
	logic retrieve = 1'b0;
	logic seq_en = 1'b0;
	logic store = 1'b0;
	logic unit_sel = 1'b0;
	logic key_strobe_n;
	logic [3:0] bus;
	logic [3:0] code;
	logic [3:0] code_oe;
	logic strobe_n;
	logic strobe_oe;
	logic dig_dis_n;
	logic addr_dis_n;
	int fail_count = 0;
	int checked = 0;
	logic [3:0] want[$];

	// Free-running 200 MHz clock.
	initial
	begin
		forever #2.5 mclk = ~mclk;
	end

	rns_store #(.STEP_CYC(STEP), .DEB_CYC(DEB)) uut (
		.i_mclk(mclk), .i_reset(reset), .i_por_n(por_n),
		.i_retrieve(retrieve), .i_seq_enable(seq_en), .i_store(store),
		.i_unit_sel(unit_sel), .i_key_strobe_n(key_strobe_n),
		.o_key_strobe_n(strobe_n), .o_key_strobe_oe(strobe_oe),
		.i_code_line(bus), .o_code_line(code), .o_code_line_oe(code_oe),
		.o_digit_kb_dis_n(dig_dis_n), .o_addr_kb_dis_n(addr_dis_n));

	rns_dialler_model partner (
		.i_mclk(mclk), .i_strobe_n(strobe_n), .i_strobe_oe(strobe_oe),
		.i_code(code), .i_code_oe(code_oe),
		.o_key_strobe_n(key_strobe_n), .o_bus(bus));

	// Compares one value and counts it.
	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Controls move together, then rest past the bounce filter.
	task automatic set_ctl(input logic r, input logic e, input logic s,
		input logic u);
		retrieve = r;
		seq_en = e;
		store = s;
		unit_sel = u;
		repeat (DEB + 4) @(posedge mclk);
		#1;
	endtask

	// Presses a key and looks at the strobe output midway through it.
	task automatic press_watch(input logic [3:0] key, input logic exp);
		fork
			partner.press(key);
			begin
				repeat (DEB + 3) @(posedge mclk);
				#1;
				chk("strobe out", 8'(exp), 8'(strobe_n));
			end
		join
	endtask

	// Stores the first digits of want under one address key.
	task automatic save(input logic [3:0] key, input int digits);
		set_ctl(1'b0, 1'b1, 1'b1, 1'b1);
		press_watch(key, 1'b1);
		chk("address disable", 8'd0, 8'(addr_dis_n));
		for (int i = 0; i < digits; i++)
			press_watch(want[i], 1'b1);
		set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
		chk("address disable", 8'd1, 8'(addr_dis_n));
	endtask

	// Retrieves one address and compares what the dialler received.
	task automatic recall(input logic [3:0] key);
		int n;
		n = 0;
		partner.got.delete();
		set_ctl(1'b1, 1'b1, 1'b0, 1'b1);
		fork
			partner.press(key);
			begin
				while (dig_dis_n !== 1'b0 && n < 100)
				begin
					@(posedge mclk);
					#1;
					n++;
				end
				// Dropping early keeps the number from being sent twice.
				retrieve = 1'b0;
				chk("digit disable", 8'd0, 8'(dig_dis_n));
				chk("address disable", 8'd0, 8'(addr_dis_n));
				while (dig_dis_n !== 1'b1 && n < 3000)
				begin
					@(posedge mclk);
					#1;
					n++;
				end
			end
		join
		chk("count", 8'(want.size()), 8'(partner.got.size()));
		foreach (want[i])
			chk("code", 8'(want[i]), 8'(partner.got[i]));
		chk("address disable", 8'd1, 8'(addr_dis_n));
		press_watch(key, 1'b0);
		chk("digit disable", 8'd1, 8'(dig_dis_n));
		set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	// Main sequence.
	initial
	begin
		repeat (12) @(posedge mclk);
		#1;
		reset = 1'b0;
		por_n = 1'b1;
		@(posedge mclk);
		#1;
		chk("strobe out", 8'd1, 8'(strobe_n));
		chk("code enable", 8'd0, 8'(code_oe));
		chk("digit disable", 8'd1, 8'(dig_dis_n));
		press_watch(RNS_CODE_2, 1'b0);
		set_ctl(1'b0, 1'b1, 1'b0, 1'b0);
		chk("strobe enable", 8'd0, 8'(strobe_oe));
		set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
		want = '{DIG[5], RNS_CODE_PAUSE, DIG[0]};
		save(DIG[3], 3);
		recall(DIG[3]);
		want.delete();
		for (int i = 0; i < 23; i++)
			want.push_back(DIG[i % 10]);
		save(DIG[7], 23);
		void'(want.pop_back());
		recall(DIG[7]);
		want.delete();
		save(DIG[3], 0);
		recall(DIG[3]);
		end_of_test();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_of_test();
	end
endmodule // test_repertory_number_store
`default_nettype wire
